// ---- logic/pci_port_cfg.svh ----
/*
  timing and encoding constants for the pci port.
  assumes inclusion by bare name from the package and design.
*/
`ifndef PCI_PORT_CFG_SVH
`define PCI_PORT_CFG_SVH
`define CMD_MEM_READ     4'h6
`define CMD_MEM_WRITE    4'h7
`define CMD_CFG_READ     4'hA
`define CMD_CFG_WRITE    4'hB
`define RST_NS           1000
`define CLK_NS           100
`define RST_CYCLES       ((`RST_NS + `CLK_NS - 1) / `CLK_NS)
`define FIFO_DEPTH       8
`define WR_BIT           0
`endif

// ---- logic/pci_port_pkg.sv ----
/*
  types shared by the pci port.
  assumes the cfg header is on the include path.
*/
`include "pci_port_cfg.svh"
package pci_port_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [3:0]  byte_en;
    logic [31:0] data;
  } req_s;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_MADDR = 6'h02,
    ST_MDATA = 6'h04,
    ST_TWAIT = 6'h08,
    ST_TDATA = 6'h10,
    ST_TURN  = 6'h20
  } state_e;
endpackage

// ---- logic/pci_master_target_port.sv ----
/*
  pci master/target port with request fifo; config reads and writes pass through to user ports.
  assumes bus pins resolved outside from out/oe pairs, all inputs
  synchronous to CLOCK_IN, and a single-master arbitration done outside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pci_port_cfg.svh"

module req_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;
  assign in_ready_out  = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid_out = cnt_reg != '0;
  assign out_data_out  = mem[rp_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;
  always_comb begin
    wp_next  = push ? AW'(wp_reg + 1'b1) : wp_reg;
    rp_next  = pop ? AW'(rp_reg + 1'b1) : rp_reg;
    cnt_next = (AW+1)'(cnt_reg + push - pop);
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_reg] <= in_data_in;
    end
  end
endmodule

module pci_master_target_port #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 CLOCK_IN,
  input  wire logic                 RSTN_IN,
  // user side: single-word master transfers, read returns and config write data
  input  wire logic                 REQ_VALID_IN,
  output logic                      REQ_READY_OUT,
  input  wire pci_port_pkg::req_s   REQ_IN,
  output logic                      RD_VALID_OUT,
  output logic [31:0]               RD_DATA_OUT,
  output logic                      TGT_WR_VALID_OUT,
  output logic [31:0]               TGT_WR_DATA_OUT,
  // target read data source
  input  wire logic [31:0]          TGT_RD_DATA_IN,
  // address/data lines
  input  wire logic [31:0]          AD_IN,
  output logic      [31:0]          AD_OUT,
  output logic                      AD_OE_OUT,
  // command/byte-enable lines
  input  wire logic [3:0]           CBEN_IN,
  output logic      [3:0]           CBEN_OUT,
  output logic                      CBEN_OE_OUT,
  // framing and handshakes, active low
  input  wire logic                 FRAMEN_IN,
  output logic                      FRAMEN_OUT,
  output logic                      FRAMEN_OE_OUT,
  input  wire logic                 IRDYN_IN,
  output logic                      IRDYN_OUT,
  output logic                      IRDYN_OE_OUT,
  input  wire logic                 TRDYN_IN,
  output logic                      TRDYN_OUT,
  output logic                      TRDYN_OE_OUT,
  output logic                      DEVSELN_OUT,
  output logic                      DEVSELN_OE_OUT,
  // initialization select
  input  wire logic                 IDSEL_IN
);
  pci_port_pkg::state_e st_reg, st_next;
  pci_port_pkg::req_s   cur, q_data;
  logic        q_valid, q_pop;
  logic [31:0] ad_reg, ad_next;
  logic [3:0]  cbe_reg, cbe_next;
  logic        ad_oe_reg, ad_oe_next, cbe_oe_reg, cbe_oe_next;
  logic        fr_reg, fr_next, fr_oe_reg, fr_oe_next;
  logic        ir_reg, ir_next, ir_oe_reg, ir_oe_next;
  logic        tr_reg, tr_next, tr_oe_reg, tr_oe_next;
  logic        ds_reg, ds_next, ds_oe_reg, ds_oe_next;
  logic        tw_reg, tw_next, rdv_reg, rdv_next, tww_reg, tww_next;
  logic [31:0] rdd_reg, rdd_next, twd_reg, twd_next;
  logic        is_cfg, rdy_in, wr;

  req_fifo #(.WIDTH($bits(pci_port_pkg::req_s)), .DEPTH(FIFO_DEPTH)) u_q (
    .clk_in       (CLOCK_IN),
    .rstn_in      (RSTN_IN),
    .in_valid_in  (REQ_VALID_IN),
    .in_ready_out (REQ_READY_OUT),
    .in_data_in   (REQ_IN),
    .out_valid_out(q_valid),
    .out_ready_in (q_pop),
    .out_data_out (q_data)
  );
  assign cur = q_data;
  assign wr  = cur.cmd[`WR_BIT];
  assign is_cfg = IDSEL_IN && !FRAMEN_IN &&
                  (CBEN_IN == `CMD_CFG_READ || CBEN_IN == `CMD_CFG_WRITE);
  assign rdy_in = !TRDYN_IN && !ir_reg;
  assign q_pop  = (st_reg == pci_port_pkg::ST_MDATA) && rdy_in;

  always_comb begin
    st_next = st_reg;
    ad_next = ad_reg;
    cbe_next = cbe_reg;
    ad_oe_next = ad_oe_reg;
    cbe_oe_next = cbe_oe_reg;
    fr_next = 1'b1;
    fr_oe_next = 1'b0;
    ir_next = 1'b1;
    ir_oe_next = 1'b0;
    tr_next = 1'b1;
    tr_oe_next = 1'b0;
    ds_next = 1'b1;
    ds_oe_next = 1'b0;
    tw_next = tw_reg;
    rdv_next = 1'b0;
    rdd_next = rdd_reg;
    tww_next = 1'b0;
    twd_next = twd_reg;
    case (st_reg)
      pci_port_pkg::ST_IDLE: begin
        ad_oe_next = 1'b0;
        cbe_oe_next = 1'b0;
        if (is_cfg) begin
          tw_next = CBEN_IN[`WR_BIT];
          ds_next = 1'b0;
          ds_oe_next = 1'b1;
          st_next = pci_port_pkg::ST_TWAIT;
        end else if (q_valid && FRAMEN_IN && IRDYN_IN) begin
          // address with two low bits zero
          ad_next = {cur.addr[31:2], 2'b00};
          cbe_next = cur.cmd;
          ad_oe_next = 1'b1;
          cbe_oe_next = 1'b1;
          fr_next = 1'b0;
          fr_oe_next = 1'b1;
          st_next = pci_port_pkg::ST_MADDR;
        end
      end
      pci_port_pkg::ST_MADDR: begin
        cbe_next = cur.byte_en;
        // write data driven, bus released for reads
        ad_next = cur.data;
        ad_oe_next = wr;
        fr_next = 1'b1;
        fr_oe_next = 1'b1;
        // ready once data valid or capture possible
        ir_next = 1'b0;
        ir_oe_next = 1'b1;
        st_next = pci_port_pkg::ST_MDATA;
      end
      pci_port_pkg::ST_MDATA: begin
        fr_oe_next = 1'b1;
        ir_oe_next = 1'b1;
        if (rdy_in) begin
          rdv_next = !wr;
          rdd_next = AD_IN;
          ad_oe_next = 1'b0;
          cbe_oe_next = 1'b0;
          st_next = pci_port_pkg::ST_TURN;
        end else begin
          ir_next = 1'b0;
        end
      end
      pci_port_pkg::ST_TWAIT: begin
        ds_next = 1'b0;
        ds_oe_next = 1'b1;
        // target-ready with read data or write room
        tr_next = 1'b0;
        tr_oe_next = 1'b1;
        ad_next = TGT_RD_DATA_IN;
        ad_oe_next = !tw_reg;
        st_next = pci_port_pkg::ST_TDATA;
      end
      pci_port_pkg::ST_TDATA: begin
        ds_oe_next = 1'b1;
        tr_oe_next = 1'b1;
        if (!IRDYN_IN) begin
          tww_next = tw_reg;
          twd_next = AD_IN;
          ad_oe_next = 1'b0;
          st_next = pci_port_pkg::ST_TURN;
        end else begin
          ds_next = 1'b0;
          tr_next = 1'b0;
        end
      end
      pci_port_pkg::ST_TURN: begin
        ad_oe_next = 1'b0;
        cbe_oe_next = 1'b0;
        st_next = pci_port_pkg::ST_IDLE;
      end
      default: st_next = pci_port_pkg::ST_IDLE;
    endcase
  end

  // reset floats pins and clears state
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_reg <= pci_port_pkg::ST_IDLE;
      ad_reg <= 32'h00000000;
      cbe_reg <= 4'hF;
      ad_oe_reg <= 1'b0;
      cbe_oe_reg <= 1'b0;
      fr_reg <= 1'b1;
      fr_oe_reg <= 1'b0;
      ir_reg <= 1'b1;
      ir_oe_reg <= 1'b0;
      tr_reg <= 1'b1;
      tr_oe_reg <= 1'b0;
      ds_reg <= 1'b1;
      ds_oe_reg <= 1'b0;
      tw_reg <= 1'b0;
      rdv_reg <= 1'b0;
      rdd_reg <= 32'h00000000;
      tww_reg <= 1'b0;
      twd_reg <= 32'h00000000;
    end else begin
      st_reg <= st_next;
      ad_reg <= ad_next;
      cbe_reg <= cbe_next;
      ad_oe_reg <= ad_oe_next;
      cbe_oe_reg <= cbe_oe_next;
      fr_reg <= fr_next;
      fr_oe_reg <= fr_oe_next;
      ir_reg <= ir_next;
      ir_oe_reg <= ir_oe_next;
      tr_reg <= tr_next;
      tr_oe_reg <= tr_oe_next;
      ds_reg <= ds_next;
      ds_oe_reg <= ds_oe_next;
      tw_reg <= tw_next;
      rdv_reg <= rdv_next;
      rdd_reg <= rdd_next;
      tww_reg <= tww_next;
      twd_reg <= twd_next;
    end
  end

  assign AD_OUT = ad_reg;
  assign AD_OE_OUT = ad_oe_reg;
  assign CBEN_OUT = cbe_reg;
  assign CBEN_OE_OUT = cbe_oe_reg;
  assign FRAMEN_OUT = fr_reg;
  assign FRAMEN_OE_OUT = fr_oe_reg;
  assign IRDYN_OUT = ir_reg;
  assign IRDYN_OE_OUT = ir_oe_reg;
  assign TRDYN_OUT = tr_reg;
  assign TRDYN_OE_OUT = tr_oe_reg;
  assign DEVSELN_OUT = ds_reg;
  assign DEVSELN_OE_OUT = ds_oe_reg;
  assign RD_VALID_OUT = rdv_reg;
  assign RD_DATA_OUT = rdd_reg;
  assign TGT_WR_VALID_OUT = tww_reg;
  assign TGT_WR_DATA_OUT = twd_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence addr_phase_s;
    st_reg == pci_port_pkg::ST_MADDR;
  endsequence
  sequence data_phase_s;
    st_reg == pci_port_pkg::ST_MDATA && !ir_reg;
  endsequence
  cbe_master_a: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    cbe_oe_reg |-> st_reg inside {pci_port_pkg::ST_MADDR,
      pci_port_pkg::ST_MDATA, pci_port_pkg::ST_TURN})
    else $error("cbe driven while not master");
  addr_low_a: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    addr_phase_s |-> ad_reg[1:0] == 2'b00 && ad_oe_reg)
    else $error("address low bits not zero");
  byte_en_a: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    addr_phase_s ##1 data_phase_s |-> cbe_reg == cur.byte_en)
    else $error("byte enables wrong in data phase");
  frame_seq_a: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    addr_phase_s |-> !fr_reg && fr_oe_reg ##1 fr_reg)
    else $error("frame sequence broken");
  frame_own_a: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    fr_oe_reg |-> !ds_oe_reg)
    else $error("frame driven as target");
  irdy_own_a: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    !ir_reg |-> ir_oe_reg && !tr_oe_reg)
    else $error("irdy driven as target");
  wr_data_a: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    (data_phase_s and wr) |-> ad_oe_reg && ad_reg == cur.data)
    else $error("irdy without write data");
  devsel_a: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    st_reg == pci_port_pkg::ST_IDLE && is_cfg |=> !ds_reg)
    else $error("devsel not asserted after config select");
  trdy_a: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    !tr_reg && !tw_reg |-> ad_oe_reg)
    else $error("trdy without read data");
  complete_a: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    (data_phase_s and TRDYN_IN) |=> data_phase_s)
    else $error("data phase ended without target ready");
endmodule
`default_nettype wire

// ---- tb/pci_far_target.sv ----
/*
  far-side pci agent: claims memory commands, answers after a set wait.
  assumes resolved bus lines, control lines pulled up when released.
*/
`timescale 1ns/1ns
`default_nettype none
module pci_far_target (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // bus lines
  input  wire logic        frame_n_in,
  input  wire logic        irdy_n_in,
  input  wire logic [31:0] ad_in,
  input  wire logic [3:0]  cbe_in,
  output logic             trdy_n_out,
  output logic [31:0]      ad_out,
  output logic             ad_oe_out,
  // control and capture
  input  wire logic [3:0]  wait_in,
  input  wire logic [31:0] rd_data_in,
  output logic [31:0]      addr_out,
  output logic [3:0]       cmd_out,
  output logic [3:0]       be_out,
  output logic [31:0]      wr_data_out,
  output logic             frame_out,
  output logic [7:0]       done_out
);
  logic       busy_reg;
  logic [3:0] cnt_reg;
  // claim, wait, finish on both readies
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_reg <= 1'b0;
      trdy_n_out <= 1'b1;
      ad_oe_out <= 1'b0;
      done_out <= 8'h00;
    end else if (!busy_reg) begin
      if (!frame_n_in && cbe_in[3:1] == 3'h3) begin
        busy_reg <= 1'b1;
        addr_out <= ad_in;
        cmd_out <= cbe_in;
        cnt_reg <= wait_in;
      end
    end else if (!trdy_n_out && !irdy_n_in) begin
      busy_reg <= 1'b0;
      trdy_n_out <= 1'b1;
      ad_oe_out <= 1'b0;
      be_out <= cbe_in;
      wr_data_out <= ad_in;
      frame_out <= frame_n_in;
      done_out <= done_out + 8'h01;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else begin
      trdy_n_out <= 1'b0;
      ad_oe_out <= !cmd_out[0];
      ad_out <= rd_data_in;
    end
  end
endmodule
`default_nettype wire

// ---- tb/pci_master_target_port_tb.sv ----
/*
  self-checking bench for the pci port.
  assumes the cfg header and package are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pci_port_cfg.svh"
module pci_master_target_port_tb;
  logic clk, rstn, req_valid, idsel, tb_frame, tb_irdy, tb_ad_oe, tb_cbe_oe;
  logic stalled, p_trdy, p_ad_oe, p_fr, rd_v, tgt_wr_v, ad_oe, cbe_oe;
  logic fr_oe, irdy_oe, trdy_oe, dev_oe, dev_n, fr_o, irdy_o, trdy_o;
  logic [31:0] tb_ad, p_ad, p_addr, p_wd, far_rd, tgt_rd, ad, ad_o;
  logic [31:0] rd_d, tgt_wr_d, idle_pat = '0;
  logic [3:0] tb_cbe, cbe, cbe_o, p_cmd, p_be, wait_cyc;
  logic [7:0] p_done;
  logic frame_n, irdy_n, trdy_n;
  pci_port_pkg::req_s req;
  int samples_checked, bad_count, cyc;
  assign ad = ad_oe ? ad_o : p_ad_oe ? p_ad : tb_ad_oe ? tb_ad : idle_pat;
  assign cbe = cbe_oe ? cbe_o : tb_cbe_oe ? tb_cbe : idle_pat[3:0];
  assign frame_n = (fr_oe ? fr_o : 1'b1) & tb_frame;
  assign irdy_n = (irdy_oe ? irdy_o : 1'b1) & tb_irdy;
  assign trdy_n = (trdy_oe ? trdy_o : 1'b1) & p_trdy;
  pci_master_target_port #(.FIFO_DEPTH(8)) i_dut (
    .CLOCK_IN(clk), .RSTN_IN(rstn), .REQ_VALID_IN(req_valid),
    .REQ_READY_OUT(), .REQ_IN(req), .RD_VALID_OUT(rd_v),
    .RD_DATA_OUT(rd_d), .TGT_WR_VALID_OUT(tgt_wr_v),
    .TGT_WR_DATA_OUT(tgt_wr_d), .TGT_RD_DATA_IN(tgt_rd), .AD_IN(ad),
    .AD_OUT(ad_o), .AD_OE_OUT(ad_oe), .CBEN_IN(cbe), .CBEN_OUT(cbe_o),
    .CBEN_OE_OUT(cbe_oe), .FRAMEN_IN(frame_n), .FRAMEN_OUT(fr_o),
    .FRAMEN_OE_OUT(fr_oe), .IRDYN_IN(irdy_n), .IRDYN_OUT(irdy_o),
    .IRDYN_OE_OUT(irdy_oe), .TRDYN_IN(trdy_n), .TRDYN_OUT(trdy_o),
    .TRDYN_OE_OUT(trdy_oe), .DEVSELN_OUT(dev_n), .DEVSELN_OE_OUT(dev_oe),
    .IDSEL_IN(idsel));
  pci_far_target i_far (
    .clk_in(clk), .rstn_in(rstn), .frame_n_in(frame_n), .irdy_n_in(irdy_n),
    .ad_in(ad), .cbe_in(cbe), .trdy_n_out(p_trdy), .ad_out(p_ad),
    .ad_oe_out(p_ad_oe), .wait_in(wait_cyc), .rd_data_in(far_rd),
    .addr_out(p_addr), .cmd_out(p_cmd), .be_out(p_be), .wr_data_out(p_wd),
    .frame_out(p_fr), .done_out(p_done));
  // ------------------------------
  // checking and closing
  // ------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    idle_pat <= idle_pat + 32'h1357_9BDF;
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      print_verdict();
    end
  end
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic push(input logic [3:0] c, input logic [31:0] a, d);
    logic r;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{addr: a, cmd: c, byte_en: 4'h3, data: d};
    forever begin
      r = i_dut.REQ_READY_OUT;
      @(posedge clk);
      if (r) break;
      stalled = 1'b1;
      @(negedge clk);
    end
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic master_op(input logic [3:0] c, w, input logic [31:0] a, d);
    logic [7:0] n0;
    logic rv;
    n0 = p_done;
    rv = 1'b0;
    wait_cyc = w;
    far_rd = d;
    push(c, a, d);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (rd_v === 1'b1) rv = 1'b1;
      if (p_done != n0 && (c[0] || rv)) break;
    end
    chk("address", p_addr, {a[31:2], 2'h0});
    chk("command", 32'(p_cmd), 32'(c));
    chk("byte enables", 32'(p_be), 32'h3);
    chk("frame at last phase", 32'(p_fr), 32'h1);
    chk("phases done", 32'(p_done), 32'(n0 + 8'h01));
    if (c[0]) chk("write data", p_wd, d);
    else chk("read data", rv ? rd_d : ~d, d);
  endtask
  task automatic tgt_op(input logic [3:0] c, input logic [31:0] d);
    logic claim;
    claim = c[3:1] == 3'h5;
    tgt_rd = d;
    @(negedge clk);
    {tb_frame, tb_cbe, tb_cbe_oe, tb_ad, tb_ad_oe, idsel} = {1'b0, c, 1'b1,
      32'h0000_0010, 2'h3};
    @(negedge clk);
    {tb_frame, tb_irdy, tb_cbe, tb_ad, tb_ad_oe, idsel} = {2'h2, 4'h0, d,
      c[0], 1'b0};
    for (int i = 0; i < 2 && dev_n !== 1'b0; i++) @(negedge clk);
    chk("select", 32'(dev_oe && !dev_n), 32'(claim));
    for (int i = 0; i < 8 && claim && trdy_o !== 1'b0; i++) @(negedge clk);
    if (claim) begin
      chk("target ready", 32'({trdy_oe, trdy_o}), 32'h2);
      chk("target oes", 32'({cbe_oe, fr_oe, irdy_oe}), 32'h0);
      if (!c[0]) chk("target read", ad_oe ? ad_o : ~d, d);
    end
    @(negedge clk);
    {tb_irdy, tb_ad_oe, tb_cbe_oe} = 3'h4;
    if (claim && c[0]) chk("target write", tgt_wr_v ? tgt_wr_d : ~d, d);
  endtask
  task automatic fill_drain;
    logic [7:0] n0;
    n0 = p_done;
    wait_cyc = 4'hF;
    stalled = 1'b0;
    for (int i = 0; i < 10; i++)
      push(`CMD_MEM_WRITE, 32'h100 + 32'(i * 4), 32'hC0DE_0000 + 32'(i));
    chk("refused when full", 32'(stalled), 32'h1);
    for (int i = 0; i < 400 && p_done != n0 + 8'd10; i++) @(negedge clk);
    chk("drained", 32'(p_done - n0), 32'hA);
    chk("last data", p_wd, 32'hC0DE_0009);
  endtask
  task automatic reset_mid;
    wait_cyc = 4'h8;
    far_rd = 32'h0;
    push(`CMD_MEM_WRITE, 32'h0000_0200, 32'h1111_2222);
    repeat (4) @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    chk("mid oes", 32'({ad_oe, cbe_oe, fr_oe, irdy_oe, trdy_oe}), 0);
    chk("mid pulses", 32'({rd_v, tgt_wr_v, dev_oe}), 32'h0);
    chk("mid fifo", 32'(i_dut.REQ_READY_OUT), 32'h1);
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk("flushed", 32'({fr_oe, cbe_oe}), 32'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rstn, req_valid, idsel, tb_ad_oe, tb_cbe_oe, wait_cyc} = '0;
    {tb_frame, tb_irdy, req, tgt_rd, tb_ad, tb_cbe, far_rd} = {2'h3, 172'h0};
    repeat (3) @(negedge clk);
    chk("reset oes", 32'({ad_oe, cbe_oe, fr_oe, irdy_oe, trdy_oe, dev_oe}), 0);
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    master_op(`CMD_MEM_WRITE, 4'h0, 32'h1234_5673, 32'hA5A5_0F0F);
    master_op(`CMD_MEM_WRITE, 4'h2, 32'h0000_0FFE, 32'h0000_0001);
    master_op(`CMD_MEM_READ, 4'h0, 32'h8000_0001, 32'h5A5A_F0F0);
    master_op(`CMD_MEM_READ, 4'h3, 32'hFFFF_FFFF, 32'hFFFF_0000);
    reset_mid();
    master_op(`CMD_MEM_READ, 4'h1, 32'h0000_0404, 32'h0F0F_A5A5);
    tgt_op(`CMD_CFG_READ, 32'hDEAD_0001);
    tgt_op(`CMD_CFG_WRITE, 32'h0BAD_F00D);
    tgt_op(4'h2, 32'h0000_0002);
    fill_drain();
    print_verdict();
  end
endmodule
`default_nettype wire
